// file: inc/timer_channel_pkg.sv
package timer_channel_pkg;

  // byte offsets on the register bus
  localparam logic [7:0] SC_OFS   = 8'h00;
  localparam logic [7:0] CNT_OFS  = 8'h04;
  localparam logic [7:0] MOD_OFS  = 8'h08;
  localparam logic [7:0] CH_BASE  = 8'h10;
  // each channel owns two words: control at +0, value at +4
  localparam int         CH_SHIFT = 3;

  // timer control word fields
  localparam int PS_LSB    = 0;
  localparam int CLKS_LSB  = 3;
  localparam int CENTER_ALIGNED_SELECT_BIT = 5;
  localparam int TOF_BIT   = 7;

  // channel control word fields
  localparam int ELS_LSB = 2;
  localparam int MS_LSB  = 4;
  localparam int CHF_BIT = 7;

  localparam logic [1:0] CLK_OFF   = 2'h0;
  localparam logic [1:0] CLK_BUS   = 2'h1;
  localparam logic [1:0] CLK_FIXED = 2'h2;
  localparam logic [1:0] CLK_EXT   = 2'h3;

  localparam logic [15:0] MOD_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] VAL_RESET = 16'h0000;

  typedef enum logic {CNT_UP, CNT_DOWN} countDir_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] edgeLevel;
  } chCfg_t;

  typedef struct packed {
    logic       centerAligned;
    logic [1:0] clkSel;
    logic [2:0] prescale;
  } timerCfg_t;

  // counter state as seen by the channels; step marks a fresh count value
  typedef struct packed {
    logic [15:0] cnt;
    countDir_t   dir;
    logic        step;
    logic        periodStart;
  } cntState_t;

endpackage

// file: logic/timer_channel_unit.sv
`timescale 1ns/100ps
module timer_channel_unit (
  input  wire logic                         mclk,
  input  wire logic                         rstN,
  input  timer_channel_pkg::chCfg_t         cfg,
  input  timer_channel_pkg::timerCfg_t      tcfg,
  input  wire logic                         isExtShared,
  input  timer_channel_pkg::cntState_t      cs,
  input  wire logic [15:0]                  chValue,
  input  wire logic                         pinIn,
  output logic                              pinOut,
  output logic                              pinOe,
  output logic                              capture,
  output logic                              match
);
  import timer_channel_pkg::*;

  logic s1, s2, s3, pinLevel, prevLevel;
  logic own, isIc, isOc, isEpwm, isCpwm, hit, rise, fall, elsLow;
  logic next_pinLevel, next_pinOut, next_pinOe;

  always_comb begin
    isCpwm = tcfg.centerAligned;
    isIc   = !isCpwm && cfg.mode == 2'h0;
    isOc   = !isCpwm && cfg.mode == 2'h1;
    isEpwm = !isCpwm && cfg.mode[1];
    elsLow = cfg.edgeLevel[0];
    own = cfg.edgeLevel != 2'h0 && tcfg.clkSel != CLK_OFF
          && !(isExtShared && tcfg.clkSel == CLK_EXT);
    next_pinLevel = (s2 == s3) ? s3 : pinLevel;
    rise = pinLevel && !prevLevel;
    fall = !pinLevel && prevLevel;
    hit  = cs.step && cs.cnt == chValue;
    capture = isIc && own && ((cfg.edgeLevel[0] && rise) || (cfg.edgeLevel[1] && fall));
    match = hit && !isIc;
    next_pinOe  = own && !isIc;
    next_pinOut = pinOut;
    if (!own) begin
      // track the pin so toggle mode starts from its level
      next_pinOut = pinLevel;
    end else if (isOc && hit) begin
      case (cfg.edgeLevel)
        2'h1:    next_pinOut = !pinOut;
        2'h2:    next_pinOut = 1'b0;
        2'h3:    next_pinOut = 1'b1;
        default: next_pinOut = pinOut;
      endcase
    end else if (isEpwm) begin
      if (cs.periodStart) begin
        next_pinOut = !elsLow;
      end
      // match after start so a zero value gives zero duty
      if (hit) begin
        next_pinOut = elsLow;
      end
    end else if (isCpwm && hit) begin
      next_pinOut = (cs.dir == CNT_UP) ? elsLow : !elsLow;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      s1        <= 1'b0;
      s2        <= 1'b0;
      s3        <= 1'b0;
      pinLevel  <= 1'b0;
      prevLevel <= 1'b0;
      pinOut    <= 1'b0;
      pinOe     <= 1'b0;
    end else begin
      s1        <= pinIn;
      s2        <= s1;
      s3        <= s2;
      pinLevel  <= next_pinLevel;
      prevLevel <= pinLevel;
      pinOut    <= next_pinOut;
      pinOe     <= next_pinOe;
    end
  end

endmodule

// file: logic/timer_channel_pin_control.sv
// Function
// - control bits choose counter source: none, bus, fixed clock or external input
// - external clock input is synchronised to the bus clock before counting
// - with external source and edge/level 0:0, compare still runs without pin
// - pin stays with gpio when edge/level is 0:0 or clock select is 0:0
// - center-aligned select makes all active channels center PWM outputs
// - without center mode, mode field picks capture, compare or edge PWM
// - capture forces pin to edge input; edge/level picks trigger edges
// - capture edges are synchronised; outside holds pulses four bus clocks
// - compare overrides direction and toggles, clears or sets pin on match
// - toggle mode keeps previous pin level until the next match
// - edge PWM 1:0 drives high at period start, low on match
// - edge PWM with low bit set drives low at start, high on match
// - center PWM 1:0 clears on match counting up, sets counting down
// - center PWM with low bit set: sets counting up, clears counting down
// - one to eight channels, each with control and value registers
// - clock select 00 off, 01 bus, 10 fixed, 11 external
// - center mode counts up to modulo, then down to zero, repeating
// - edge PWM period is modulo value plus one counter clocks
// - selected capture edge copies counter into channel value and sets flag
`timescale 1ns/100ps
module timer_channel_pin_control #(
  parameter int CH_NUM        = 4,
  parameter int EXT_SHARED_CH = 0
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              fixedClkIn,
  input  wire logic              extCountClockIn,
  input  wire logic [CH_NUM-1:0] channelPinIn,
  output logic [CH_NUM-1:0]      channelPinOut,
  output logic [CH_NUM-1:0]      channelPinOe
);
  import timer_channel_pkg::*;

  logic              rstMeta, rstN;
  timerCfg_t         tcfg, next_tcfg;
  logic [15:0]       modVal, next_modVal;
  logic              tof, next_tof;
  chCfg_t            chCfg [CH_NUM];
  chCfg_t            next_chCfg [CH_NUM];
  logic [15:0]       chVal [CH_NUM];
  logic [15:0]       next_chVal [CH_NUM];
  logic [CH_NUM-1:0] chFlag, next_chFlag, capEvt, matchEvt, pinOutW, pinOeW;
  cntState_t         cs, next_cs;
  logic [6:0]        preCnt, next_preCnt, preMask;
  logic              e1, e2, e3, extLevel, extPrev, next_extLevel;
  logic              f1, f2, f3, fixLevel, fixPrev, next_fixLevel;
  logic              srcTick, cntTick;
  logic              access, wrAcc, hitSc, hitCnt, hitMod, hitCh, chWord, mapped;
  logic [4:0]        chIdx;
  logic [31:0]       next_prdata;
  logic              next_pready, next_pslverr;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // ---------------- bus decode ----------------
  always_comb begin
    access = psel && penable && pready;
    wrAcc  = access && pwrite;
    hitSc  = paddr == SC_OFS;
    hitCnt = paddr == CNT_OFS;
    hitMod = paddr == MOD_OFS;
    chIdx  = 5'((paddr - CH_BASE) >> CH_SHIFT);
    chWord = paddr[2];
    hitCh  = paddr >= CH_BASE && paddr[1:0] == 2'h0 && 32'(chIdx) < CH_NUM;
    mapped = (hitSc || hitCnt || hitMod || hitCh) && paddr[1:0] == 2'h0;
  end

  // ---------------- clock sources ----------------
  always_comb begin
    next_extLevel = (e2 == e3) ? e3 : extLevel;
    next_fixLevel = (f2 == f3) ? f3 : fixLevel;
    case (tcfg.clkSel)
      CLK_BUS:   srcTick = 1'b1;
      CLK_FIXED: srcTick = fixLevel && !fixPrev;
      CLK_EXT:   srcTick = extLevel && !extPrev;
      default:   srcTick = 1'b0;
    endcase
    preMask     = 7'h7F >> (3'h7 - tcfg.prescale);
    cntTick     = srcTick && ((preCnt & preMask) == preMask);
    next_preCnt = srcTick ? preCnt + 7'h01 : preCnt;
    if (wrAcc && hitCnt) begin
      next_preCnt = 7'h00;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      e1       <= 1'b0;
      e2       <= 1'b0;
      e3       <= 1'b0;
      extLevel <= 1'b0;
      extPrev  <= 1'b0;
      f1       <= 1'b0;
      f2       <= 1'b0;
      f3       <= 1'b0;
      fixLevel <= 1'b0;
      fixPrev  <= 1'b0;
      preCnt   <= 7'h00;
    end else begin
      e1       <= extCountClockIn;
      e2       <= e1;
      e3       <= e2;
      extLevel <= next_extLevel;
      extPrev  <= extLevel;
      f1       <= fixedClkIn;
      f2       <= f1;
      f3       <= f2;
      fixLevel <= next_fixLevel;
      fixPrev  <= fixLevel;
      preCnt   <= next_preCnt;
    end
  end

  // ---------------- counter ----------------
  always_comb begin
    next_cs             = cs;
    next_cs.step        = 1'b0;
    next_cs.periodStart = 1'b0;
    next_tof            = tof;
    if (wrAcc && hitSc && !pwdata[TOF_BIT]) begin
      next_tof = 1'b0;
    end
    if (wrAcc && hitCnt) begin
      // any write restarts the count
      next_cs.cnt = CNT_RESET;
      next_cs.dir = CNT_UP;
    end else if (cntTick) begin
      next_cs.step = 1'b1;
      if (tcfg.centerAligned) begin
        // up to modulo then down to zero
        if (cs.dir == CNT_UP && cs.cnt >= modVal && modVal != 16'h0000) begin
          next_cs.dir = CNT_DOWN;
          next_cs.cnt = cs.cnt - 16'h0001;
        end else if (cs.dir == CNT_DOWN && cs.cnt != 16'h0000) begin
          next_cs.cnt = cs.cnt - 16'h0001;
          next_tof    = next_tof || cs.cnt == 16'h0001;
        end else begin
          next_cs.dir = CNT_UP;
          next_cs.cnt = cs.cnt + 16'h0001;
        end
      end else begin
        // wrap after modulo gives modulo plus one counts
        next_cs.dir = CNT_UP;
        if (cs.cnt == modVal && modVal != 16'h0000) begin
          next_cs.cnt = 16'h0000;
        end else begin
          next_cs.cnt = cs.cnt + 16'h0001;
        end
        next_cs.periodStart = next_cs.cnt == 16'h0000;
        next_tof            = next_tof || next_cs.periodStart;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      cs  <= '{cnt: CNT_RESET, dir: CNT_UP, step: 1'b0, periodStart: 1'b0};
      tof <= 1'b0;
    end else begin
      cs  <= next_cs;
      tof <= next_tof;
    end
  end

  // ---------------- channels ----------------
  for (genvar i = 0; i < CH_NUM; i++) begin : gChan
    timer_channel_unit uChan (
      .mclk        (mclk),
      .rstN        (rstN),
      .cfg         (chCfg[i]),
      .tcfg        (tcfg),
      .isExtShared (i == EXT_SHARED_CH),
      .cs          (cs),
      .chValue     (chVal[i]),
      .pinIn       (channelPinIn[i]),
      .pinOut      (pinOutW[i]),
      .pinOe       (pinOeW[i]),
      .capture     (capEvt[i]),
      .match       (matchEvt[i])
    );
  end

  assign channelPinOut = pinOutW;
  assign channelPinOe  = pinOeW;

  // ---------------- register file ----------------
  always_comb begin
    next_tcfg   = tcfg;
    next_modVal = modVal;
    next_chFlag = chFlag;
    if (wrAcc && hitSc) begin
      next_tcfg.centerAligned = pwdata[CENTER_ALIGNED_SELECT_BIT];
      next_tcfg.clkSel        = pwdata[CLKS_LSB +: 2];
      next_tcfg.prescale      = pwdata[PS_LSB +: 3];
    end
    if (wrAcc && hitMod) begin
      next_modVal = pwdata[15:0];
    end
    for (int i = 0; i < CH_NUM; i++) begin
      next_chCfg[i] = chCfg[i];
      next_chVal[i] = chVal[i];
      if (wrAcc && hitCh && 32'(chIdx) == i) begin
        if (!chWord) begin
          next_chCfg[i].mode      = pwdata[MS_LSB +: 2];
          next_chCfg[i].edgeLevel = pwdata[ELS_LSB +: 2];
          if (!pwdata[CHF_BIT]) begin
            next_chFlag[i] = 1'b0;
          end
        end else begin
          next_chVal[i] = pwdata[15:0];
        end
      end
      if (capEvt[i]) begin
        next_chVal[i] = cs.cnt;
      end
      if (capEvt[i] || matchEvt[i]) begin
        next_chFlag[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      tcfg   <= '{centerAligned: 1'b0, clkSel: CLK_OFF, prescale: 3'h0};
      modVal <= MOD_RESET;
      chFlag <= '0;
      for (int i = 0; i < CH_NUM; i++) begin
        chCfg[i] <= '{mode: 2'h0, edgeLevel: 2'h0};
        chVal[i] <= VAL_RESET;
      end
    end else begin
      tcfg   <= next_tcfg;
      modVal <= next_modVal;
      chFlag <= next_chFlag;
      for (int i = 0; i < CH_NUM; i++) begin
        chCfg[i] <= next_chCfg[i];
        chVal[i] <= next_chVal[i];
      end
    end
  end

  // ---------------- bus answer ----------------
  // no wait state: pready rises in the first access cycle
  always_comb begin
    next_pready  = psel && !penable;
    next_pslverr = psel && !penable && !mapped;
    next_prdata  = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (hitSc) begin
        next_prdata[TOF_BIT]           = tof;
        next_prdata[CENTER_ALIGNED_SELECT_BIT]         = tcfg.centerAligned;
        next_prdata[CLKS_LSB +: 2]     = tcfg.clkSel;
        next_prdata[PS_LSB +: 3]       = tcfg.prescale;
      end else if (hitCnt) begin
        next_prdata[15:0] = cs.cnt;
      end else if (hitMod) begin
        next_prdata[15:0] = modVal;
      end else if (hitCh) begin
        for (int i = 0; i < CH_NUM; i++) begin
          if (32'(chIdx) == i) begin
            if (chWord) begin
              next_prdata[15:0] = chVal[i];
            end else begin
              next_prdata[CHF_BIT]        = chFlag[i];
              next_prdata[MS_LSB +: 2]    = chCfg[i].mode;
              next_prdata[ELS_LSB +: 2]   = chCfg[i].edgeLevel;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule

// file: tb/timer_pin_asserts.sv
`timescale 1ns/100ps
module timer_pin_asserts #(
  parameter int CH_NUM = 4
) (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [CH_NUM-1:0] channelPinOe
);
  import timer_channel_pkg::*;
  logic wrDone;
  logic mapped;
  assign wrDone = psel && penable && pready && pwrite;
  // three fixed words, then two words per channel
  assign mapped = paddr[1:0] == 2'h0 && (paddr < 8'h0C || (paddr >= CH_BASE && int'(paddr) < 16 + 8 * CH_NUM));
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  setup_gets_ready_a : assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  ready_single_a : assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  idle_rdata_a : assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  err_with_ready_a : assert property (pslverr |-> pready)
    else $error("error without ready");
  decode_err_a : assert property (psel && !penable |=> pslverr == !$past(mapped))
    else $error("address decode error wrong");
  reset_pins_free_a : assert property ($rose(rst_n) |-> channelPinOe == '0 ##1 channelPinOe == '0)
    else $error("pin owned after reset");
  clock_off_free_a : assert property (wrDone && paddr == SC_OFS && pwdata[CLKS_LSB+:2] == CLK_OFF
      |-> ##[1:3] channelPinOe == '0)
    else $error("pin kept with clock off");
  owner_after_write_a : assert property ($changed(channelPinOe)
      |-> $past(wrDone) || $past(wrDone, 2) || $past(wrDone, 3))
    else $error("pin ownership changed without write");
endmodule

bind timer_channel_pin_control timer_pin_asserts #(.CH_NUM(CH_NUM)) i_pin_asserts (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .channelPinOe(channelPinOe)
);

// file: tb/timer_pin_partner.sv
`timescale 1ns/100ps
module timer_pin_partner #(
  parameter int CH_NUM = 4
) (
  input  wire logic              mclk,
  input  wire logic [CH_NUM-1:0] pinOut,
  input  wire logic [CH_NUM-1:0] pinOe,
  output logic [CH_NUM-1:0]      pinIn,
  output logic                   ext_count_clock_in,
  output logic                   fixedClk
);
  logic [CH_NUM-1:0] level;
  initial begin
    level = '0;
    ext_count_clock_in = 1'b0;
    fixedClk = 1'b0;
  end
  // outside drive shows only while the timer lets go
  assign pinIn = (pinOe & pinOut) | (~pinOe & level);
  // eight bus clocks per edge, under the quarter-rate ceiling
  task automatic clockEdges(input logic useExt, input int n);
    repeat (n) begin
      repeat (4) @(posedge mclk);
      ext_count_clock_in <= useExt;
      fixedClk <= !useExt;
      repeat (4) @(posedge mclk);
      ext_count_clock_in <= 1'b0;
      fixedClk <= 1'b0;
    end
  endtask
  // caller holds each level four bus clocks or more
  task automatic setLevel(input int ch, input logic v);
    level[ch] <= v;
  endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import timer_channel_pkg::*;
  localparam logic [31:0] BUS   = 32'(CLK_BUS) << CLKS_LSB;
  localparam int          PWM_HI [4] = '{20, 16, 40, 24};
  localparam logic [31:0] OC_CTRL [3] = '{32'h18, 32'h1C, 32'h14};
  localparam int          OC_HI [3] = '{0, 36, 18};
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fixedClkIn;
  logic        extCountClockIn;
  logic [3:0]  channelPinIn;
  logic [3:0]  channelPinOut;
  logic [3:0]  channelPinOe;
  int          miscompares = 0;
  int          samplesChecked = 0;

  always #12.5 mclk = ~mclk;

  timer_channel_pin_control #(.CH_NUM(4), .EXT_SHARED_CH(0)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fixedClkIn(fixedClkIn), .extCountClockIn(extCountClockIn), .channelPinIn(channelPinIn),
    .channelPinOut(channelPinOut), .channelPinOe(channelPinOe)
  );
  timer_pin_partner #(.CH_NUM(4)) i_partner (
    .mclk(mclk), .pinOut(channelPinOut), .pinOe(channelPinOe), .pinIn(channelPinIn),
    .ext_count_clock_in(extCountClockIn), .fixedClk(fixedClkIn)
  );

  task automatic stop_test();
    if (miscompares == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one idle cycle after each transfer keeps every signal to one change per edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    if (n >= 50) begin
      check("ready wait", 32'h1, 32'h0);
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    xfer(1'b1, a, d, unused);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0, d);
  endtask

  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(what, exp, d);
  endtask

  task automatic duty(input int ch, input int cycles, output int highs);
    highs = 0;
    repeat (cycles) begin
      @(posedge mclk);
      if (channelPinIn[ch] === 1'b1) highs++;
    end
  endtask

  initial begin
    logic [31:0] c0;
    logic [31:0] c1;
    logic [31:0] v;
    int          h;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rdChk("modulo reset", MOD_OFS, 32'(MOD_RESET));
    wr(MOD_OFS, 32'hFFFF1234);
    rdChk("modulo", MOD_OFS, 32'h1234);
    wr(8'h2C, 32'h0000ABCD);
    rdChk("last channel value", 8'h2C, 32'hABCD);
    rdChk("past last channel", 8'h30, 32'h0);
    rdChk("gap word", 8'h0C, 32'h0);
    wr(CNT_OFS, 32'h0);
    repeat (20) @(posedge mclk);
    rdChk("stopped counter", CNT_OFS, 32'h0);
    wr(SC_OFS, BUS);
    rd(CNT_OFS, c0);
    rd(CNT_OFS, c1);
    check("bus counter step", c0 + 32'h3, c1);
    // prescale 2 divides by four: ten counts in forty bus clocks
    wr(SC_OFS, BUS | 32'h2);
    wr(CNT_OFS, 32'h0);
    repeat (40) @(posedge mclk);
    rdChk("prescaled count", CNT_OFS, 32'hA);
    for (int s = 0; s < 2; s++) begin
      wr(CH_BASE, 32'h10);
      wr(CH_BASE + 8'h04, 32'h2);
      wr(SC_OFS, 32'(s ? CLK_EXT : CLK_FIXED) << CLKS_LSB);
      wr(CNT_OFS, 32'h0);
      i_partner.clockEdges(s[0], 5);
      repeat (10) @(posedge mclk);
      rdChk("edge count", CNT_OFS, 32'h5);
      rdChk("shared channel flag", CH_BASE, 32'h90);
    end
    wr(MOD_OFS, 32'h8);
    wr(8'h1C, 32'h5);
    for (int p = 0; p < 4; p++) begin
      wr(SC_OFS, BUS | (32'(p > 1) << CENTER_ALIGNED_SELECT_BIT));
      wr(8'h18, p % 2 ? 32'h34 : 32'h28);
      repeat (20) @(posedge mclk);
      duty(1, p > 1 ? 64 : 36, h);
      check("pwm high cycles", 32'(PWM_HI[p]), 32'(h));
      check("pwm ownership", 32'h2, {28'h0, channelPinOe});
    end
    wr(SC_OFS, BUS);
    for (int k = 0; k < 3; k++) begin
      wr(8'h18, OC_CTRL[k]);
      repeat (20) @(posedge mclk);
      duty(1, 36, h);
      check("compare high cycles", 32'(OC_HI[k]), 32'(h));
    end
    wr(SC_OFS, 32'h0);
    repeat (3) @(posedge mclk);
    check("clock off releases", 32'h0, {28'h0, channelPinOe});
    wr(SC_OFS, BUS);
    wr(MOD_OFS, 32'h0);
    wr(8'h20, 32'h08);
    wr(CNT_OFS, 32'h0);
    i_partner.setLevel(2, 1'b1);
    repeat (10) @(posedge mclk);
    rdChk("rise ignored", 8'h20, 32'h08);
    check("capture pin input", 32'h2, {28'h0, channelPinOe});
    i_partner.setLevel(2, 1'b0);
    repeat (10) @(posedge mclk);
    rdChk("fall captured", 8'h20, 32'h88);
    wr(8'h20, 32'h04);
    rd(CNT_OFS, c0);
    i_partner.setLevel(2, 1'b1);
    repeat (6) @(posedge mclk);
    rd(CNT_OFS, c1);
    rd(8'h24, v);
    check("capture window", 32'h1, 32'(v > c0 && v < c1));
    rdChk("capture flag", 8'h20, 32'h84);
    wr(8'h20, 32'h0C);
    i_partner.setLevel(2, 1'b0);
    repeat (10) @(posedge mclk);
    rdChk("any edge captured", 8'h20, 32'h8C);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    check("pins released", 32'h0, {28'h0, channelPinOe});
    rdChk("modulo cleared", MOD_OFS, 32'h0);
    stop_test();
  end
endmodule
